// ===== src/bst_tap.sv
`timescale 1ns/100ps

module bst_tap #(
   parameter bst_pkg::bst_id_t ID_VALUE = 32'h0A5C_3001  // Arbitrary value, LSB set
) (
   input  wire logic          CLK,
   input  wire logic          RST_B,
   input  wire logic          TCK,
   input  wire logic          TMS,
   input  wire logic          TDI,
   input  wire bst_pkg::bst_ring_t PIN_RING,
   output bst_pkg::bst_state_t     TAP_STATE,
   output logic               TDO,
   output logic               TDO_OE,
   output logic               EXTEST_ON,
   output logic               OUT_FLOAT,
   output bst_pkg::bst_ring_t BSR_DRIVE
);
   import bst_pkg::*;

   bst_link_if lnk ();

   // Pin synchronisers and edge finder
   bst_sync u_sync (
      .clk    (CLK),
      .rst_b  (RST_B),
      .pin_in ({TDI, TMS, TCK}),
      .lnk    (lnk.sync)
   );

   // Controller state machine
   bst_fsm u_fsm (
      .clk   (CLK),
      .rst_b (RST_B),
      .lnk   (lnk.fsm)
   );

   bst_instr_t test_instruction;
   bst_instr_t ir_shift;
   logic       bypass_bit;
   bst_id_t    identification_code;
   bst_ring_t  bsr_shift;
   bst_ring_t  bsr_update;

   // Instruction decode; reserved codes fall back to the bypass path
   wire op_extest  = (test_instruction == `BST_OP_EXTEST);
   wire op_idread  = (test_instruction == `BST_OP_IDREAD);
   wire op_samplez = (test_instruction == `BST_OP_SAMPLEZ);
   wire op_sample  = (test_instruction == `BST_OP_SAMPLE);
   wire sel_bsr    = op_extest | op_samplez | op_sample;
   wire sel_id     = op_idread;
   wire sel_byp    = ~sel_bsr & ~sel_id;

   // State decode
   wire st_reset  = (lnk.state == ST_RESET);
   wire st_cap_ir = (lnk.state == ST_CAP_IR);
   wire st_sh_ir  = (lnk.state == ST_SH_IR);
   wire st_upd_ir = (lnk.state == ST_UPD_IR);
   wire st_cap_dr = (lnk.state == ST_CAP_DR);
   wire st_sh_dr  = (lnk.state == ST_SH_DR);
   wire st_upd_dr = (lnk.state == ST_UPD_DR);
   wire st_shift  = st_sh_ir | st_sh_dr;

   // Actions taken on a rising test clock edge in the current state
   wire rise      = lnk.tck_rise;
   wire cap_ir    = rise & st_cap_ir;
   wire shift_ir  = rise & st_sh_ir;
   wire load_ir   = rise & st_upd_ir;
   wire cap_dr    = rise & st_cap_dr;
   wire shift_dr  = rise & st_sh_dr;
   wire upd_dr    = rise & st_upd_dr;
   wire new_byp   = load_ir & (ir_shift == `BST_OP_BYPASS);

   // Instruction bit that will leave toward the serial output
   wire ir_lsb    = ir_shift[0];

   // Data register bit at the serial output, one path chosen at a time
   wire dr_lsb    = sel_bsr ? bsr_shift[0] :
                    sel_id  ? identification_code[0] : bypass_bit;

   wire next_tdo  = st_sh_ir ? ir_lsb : dr_lsb;

   // Instruction shift stage: capture pattern, then serial load from the top
   always_ff @(posedge CLK) begin
      if (!RST_B)        ir_shift <= `BST_OP_IDREAD;
      else if (cap_ir)   ir_shift <= `BST_IR_CAPTURE;
      else if (shift_ir) ir_shift <= {lnk.tdi, ir_shift[`BST_IR_W-1:1]};
   end

   // Active instruction, changed only by update or by the reset state
   // Held in the reset state at once, so a test mode drops at the next fall
   always_ff @(posedge CLK) begin
      if (!RST_B)                 test_instruction <= `BST_OP_IDREAD;
      else if (st_reset)          test_instruction <= `BST_OP_IDREAD;
      else if (load_ir)           test_instruction <= ir_shift;
   end

   // Bypass cell: cleared when the bypass code is loaded and at capture
   always_ff @(posedge CLK) begin
      if (!RST_B)                    bypass_bit <= 1'h0;
      else if (new_byp)              bypass_bit <= 1'h0;
      else if (cap_dr & sel_byp)     bypass_bit <= 1'h0;
      else if (shift_dr & sel_byp)   bypass_bit <= lnk.tdi;
   end

   // Identification register: fixed code captured, then shifted out
   always_ff @(posedge CLK) begin
      if (!RST_B)                  identification_code <= ID_VALUE;
      else if (cap_dr & sel_id)    identification_code <= ID_VALUE;
      else if (shift_dr & sel_id)
         identification_code <= {lnk.tdi, identification_code[`BST_ID_W-1:1]};
   end

   // Boundary scan shift stage: pin ring snapshot, then serial shift
   always_ff @(posedge CLK) begin
      if (!RST_B)                  bsr_shift <= '0;
      else if (cap_dr & sel_bsr)   bsr_shift <= PIN_RING;
      else if (shift_dr & sel_bsr)
         bsr_shift <= {lnk.tdi, bsr_shift[`BST_BSR_W-1:1]};
   end

   // Boundary scan update latch; output bus enable cell preset high
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         bsr_update               <= '0;
         bsr_update[`BST_OBT_BIT] <= 1'h1;
      end else if (st_reset) begin
         bsr_update[`BST_OBT_BIT] <= 1'h1;
      end else if (upd_dr & (op_extest | op_sample)) begin
         bsr_update               <= bsr_shift;
      end
   end

   // Serial output and its driver change only on falling edges
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         TDO    <= 1'h0;
         TDO_OE <= 1'h0;
      end else if (lnk.tck_fall) begin
         TDO    <= next_tdo;
         TDO_OE <= st_shift;
      end
   end

   // Test mode outputs toward the memory pin drivers, also on falling edges
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         EXTEST_ON <= 1'h0;
         OUT_FLOAT <= 1'h0;
         BSR_DRIVE <= '0;
      end else if (lnk.tck_fall) begin
         EXTEST_ON <= op_extest;
         OUT_FLOAT <= op_samplez | (op_extest & ~bsr_update[`BST_OBT_BIT]);
         BSR_DRIVE <= bsr_update;
      end
   end

   // Controller state seen from outside, registered
   always_ff @(posedge CLK) begin
      if (!RST_B) TAP_STATE <= ST_RESET;
      else        TAP_STATE <= lnk.state;
   end

endmodule : bst_tap

// ===== src/bst_defines.svh
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH

`define BST_IR_W        3
`define BST_BSR_W       109
`define BST_ID_W        32
`define BST_OBT_BIT     108
`define BST_IR_CAPTURE  3'h1
`define BST_OP_EXTEST   3'h0
`define BST_OP_IDREAD   3'h1
`define BST_OP_SAMPLEZ  3'h2
`define BST_OP_SAMPLE   3'h4
`define BST_OP_BYPASS   3'h7
`define BST_RST_TCK     1'h0
`define BST_RST_TMS     1'h1
`define BST_RST_TDI     1'h1

`endif

// ===== src/bst_pkg.sv
`include "bst_defines.svh"

package bst_pkg;

   // Controller states, Gray coded along the usual walk
   typedef enum logic [3:0] {
      ST_RESET   = 4'h0, ST_IDLE    = 4'h1, ST_SEL_DR  = 4'h3, ST_CAP_DR  = 4'h2,
      ST_SH_DR   = 4'h6, ST_EX1_DR  = 4'h7, ST_PAU_DR  = 4'h5, ST_EX2_DR  = 4'h4,
      ST_UPD_DR  = 4'hC, ST_SEL_IR  = 4'hD, ST_CAP_IR  = 4'hF, ST_SH_IR   = 4'hE,
      ST_EX1_IR  = 4'hA, ST_PAU_IR  = 4'hB, ST_EX2_IR  = 4'h9, ST_UPD_IR  = 4'h8
   } bst_state_t;

   typedef logic [`BST_IR_W-1:0]  bst_instr_t;
   typedef logic [`BST_BSR_W-1:0] bst_ring_t;
   typedef logic [`BST_ID_W-1:0]  bst_id_t;

endpackage : bst_pkg

// ===== src/bst_link_if.sv
`timescale 1ns/100ps

interface bst_link_if;
   logic                tck_rise;
   logic                tck_fall;
   logic                tms;
   logic                tdi;
   bst_pkg::bst_state_t state;

   modport sync (output tck_rise, output tck_fall, output tms, output tdi);
   modport fsm  (input tck_rise, input tms, output state);
   modport core (input tck_rise, input tck_fall, input tdi, input state);
endinterface : bst_link_if

// ===== src/bst_sync.sv
`timescale 1ns/100ps

module bst_sync (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic [2:0] pin_in,
   bst_link_if.sync       lnk
);
   import bst_pkg::*;

   localparam logic [2:0] RST_VAL = {`BST_RST_TDI, `BST_RST_TMS, `BST_RST_TCK};

   logic [2:0] meta;
   logic [2:0] stab;
   logic       tck_prev;

   // Two-stage synchroniser per test pin; first stage feeds only the second
   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            meta[i] <= RST_VAL[i];
            stab[i] <= RST_VAL[i];
         end else begin
            meta[i] <= pin_in[i];
            stab[i] <= meta[i];
         end
      end
   end

   // Edge history of the settled test clock
   always_ff @(posedge clk) begin
      if (!rst_b) tck_prev <= `BST_RST_TCK;
      else        tck_prev <= stab[0];
   end

   // Edge strobes and settled data
   assign lnk.tck_rise = stab[0] & ~tck_prev;
   assign lnk.tck_fall = ~stab[0] & tck_prev;
   assign lnk.tms      = stab[1];
   assign lnk.tdi      = stab[2];

endmodule : bst_sync

// ===== src/bst_fsm.sv
`timescale 1ns/100ps

module bst_fsm (
   input wire logic clk,
   input wire logic rst_b,
   bst_link_if.fsm  lnk
);
   import bst_pkg::*;

   bst_state_t state;
   bst_state_t next_state;

   // Standard transition table on the sampled mode select level
   always_comb begin
      next_state = state;
      case (state)
         ST_RESET:  next_state = lnk.tms ? ST_RESET  : ST_IDLE;
         ST_IDLE:   next_state = lnk.tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: next_state = lnk.tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: next_state = lnk.tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  next_state = lnk.tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: next_state = lnk.tms ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: next_state = lnk.tms ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: next_state = lnk.tms ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: next_state = lnk.tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: next_state = lnk.tms ? ST_RESET  : ST_CAP_IR;
         ST_CAP_IR: next_state = lnk.tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  next_state = lnk.tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: next_state = lnk.tms ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: next_state = lnk.tms ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: next_state = lnk.tms ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: next_state = lnk.tms ? ST_SEL_DR : ST_IDLE;
         default:   next_state = ST_RESET;
      endcase
   end

   // State advances only on a rising test clock edge
   always_ff @(posedge clk) begin
      if (!rst_b)            state <= ST_RESET;
      else if (lnk.tck_rise) state <= next_state;
   end

   assign lnk.state = state;

endmodule : bst_fsm

// ===== verification/bst_host.sv
`timescale 1ns/100ps

module bst_host (
   input  wire logic clk,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   // Test clock rests low between frames, pulled-up lines rest high
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // One test clock period of 17 system clocks; output taken just before the rise
   task automatic step(input logic m, input logic d, output logic seen);
      @(negedge clk);
      tms = m;
      tdi = d;
      repeat (8) @(negedge clk);
      seen = tdo;
      tck = 1'b1;
      repeat (8) @(negedge clk);
      tck = 1'b0;
   endtask : step
endmodule : bst_host

// ===== verification/bst_tap_props.sv
`timescale 1ns/100ps

module bst_tap_props (
   input wire logic                CLK,
   input wire logic                RST_B,
   input wire logic                TCK,
   input wire logic                TMS,
   input wire logic                TDI,
   input wire bst_pkg::bst_ring_t  PIN_RING,
   input wire bst_pkg::bst_state_t TAP_STATE,
   input wire logic                TDO,
   input wire logic                TDO_OE,
   input wire logic                EXTEST_ON,
   input wire logic                OUT_FLOAT,
   input wire bst_pkg::bst_ring_t  BSR_DRIVE
);
   import bst_pkg::*;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);

   logic       tck_q;
   logic [2:0] high_run;
   wire        tck_rise = TCK && !tck_q;

   // Counts consecutive test clock rises seen with mode select high
   always_ff @(posedge CLK) begin
      tck_q <= TCK;
      if (!RST_B) high_run <= 3'h0;
      else if (tck_rise) high_run <= !TMS ? 3'h0 : (high_run == 3'h7) ? high_run : high_run + 3'h1;
   end

   chk_oe_rise_shift: assert property (
      $rose(TDO_OE) |-> TAP_STATE inside {ST_SH_DR, ST_SH_IR}) else $error("enable rose off shift");
   chk_oe_stays_shift: assert property (
      TDO_OE |-> TAP_STATE inside {ST_SH_DR, ST_EX1_DR, ST_SH_IR, ST_EX1_IR})
      else $error("enable high off shift");
   chk_reset_values: assert property (
      $rose(RST_B) |-> TAP_STATE == ST_RESET && !TDO_OE && !EXTEST_ON && !OUT_FLOAT)
      else $error("bad values after reset");
   chk_tdo_on_fall: assert property (
      $changed(TDO) |-> !TCK) else $error("serial out moved with clock high");
   chk_oe_on_fall: assert property (
      $changed(TDO_OE) |-> !TCK) else $error("enable moved with clock high");
   chk_state_on_rise: assert property (
      $changed(TAP_STATE) |-> TCK) else $error("state moved with clock low");
   chk_five_high: assert property (
      high_run >= 3'h5 |-> ##[0:8] TAP_STATE == ST_RESET) else $error("no reset after five highs");
   chk_extest_on_fall: assert property (
      $changed(EXTEST_ON) |-> !TCK) else $error("extest flag moved with clock high");
   chk_drive_on_fall: assert property (
      $changed(BSR_DRIVE) |-> !TCK) else $error("update latch moved with clock high");

   cov_dr_shift: cover property (TAP_STATE == ST_SH_DR && TDO_OE);
   cov_ir_shift: cover property (TAP_STATE == ST_SH_IR && TDO_OE);
   cov_extest:   cover property ($rose(EXTEST_ON));
endmodule : bst_tap_props

// ===== verification/boundary_scan_tap_test.sv
`timescale 1ns/100ps

module boundary_scan_tap_test;
   import bst_pkg::*;
   localparam bst_id_t   ID_SET = 32'h0C3E_5A01; // Arbitrary value, LSB set
   localparam bst_ring_t PAT    = {9'h0A3, {25{4'h9}}};
   logic       CLK;
   logic       RST_B;
   bst_ring_t  PIN_RING;
   wire        TCK, TMS, TDI, tdo_pin;
   logic       TDO, TDO_OE, EXTEST_ON, OUT_FLOAT;
   bst_state_t TAP_STATE;
   bst_ring_t  BSR_DRIVE;
   int         bad_count = 0;
   int         checks_done = 0;
   int         cycles = 0;

   bst_tap #(.ID_VALUE(ID_SET)) dut (.CLK(CLK), .RST_B(RST_B), .TCK(TCK), .TMS(TMS),
      .TDI(TDI), .PIN_RING(PIN_RING), .TAP_STATE(TAP_STATE), .TDO(TDO), .TDO_OE(TDO_OE),
      .EXTEST_ON(EXTEST_ON), .OUT_FLOAT(OUT_FLOAT), .BSR_DRIVE(BSR_DRIVE));
   assign tdo_pin = TDO_OE ? TDO : 1'bz;
   bst_host host (.clk(CLK), .tck(TCK), .tms(TMS), .tdi(TDI), .tdo(tdo_pin));

   task automatic check(input string what, input bst_ring_t seen, input bst_ring_t exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up

   // Idle to capture, n shifts, update, back to idle
   task automatic scan(input logic ir, input int n, input bst_ring_t din, output bst_ring_t dout);
      logic s;
      dout = '0;
      host.step(1'b1, 1'b1, s);
      if (ir) host.step(1'b1, 1'b1, s);
      host.step(1'b0, 1'b1, s);
      host.step(1'b0, 1'b1, s);
      for (int i = 0; i < n; i++) begin
         host.step(i == n - 1, din[i], s);
         dout[i] = s;
      end
      host.step(1'b1, 1'b1, s);
      host.step(1'b0, 1'b1, s);
   endtask : scan

   task automatic t_power_up;
      check("state", TAP_STATE, ST_RESET);
      check("tdo pin", tdo_pin, 1'bz);
   endtask : t_power_up

   task automatic t_id_read;
      bst_ring_t got;
      logic      s;
      host.step(1'b0, 1'b1, s);
      scan(1'b0, 32, '0, got);
      check("id", got, ID_SET);
   endtask : t_id_read

   // Reserved codes act as bypass
   task automatic t_bypass;
      bst_ring_t got;
      for (int k = 3; k < 8; k++) begin
         if (k == 4) continue;
         scan(1'b1, 3, bst_ring_t'(k), got);
         check("ir capture", got, 3'h1);
         scan(1'b0, 4, 4'hD, got);
         check("bypass", got, 4'hA);
      end
   endtask : t_bypass

   // Preload, sample-float and external test on the pin ring
   task automatic t_ring;
      bst_ring_t got;
      PIN_RING = PAT;
      for (int k = 4; k >= 0; k -= 2) begin
         scan(1'b1, 3, bst_ring_t'(k), got);
         scan(1'b0, $bits(bst_ring_t), ~PAT, got);
         repeat (4) @(negedge CLK);
         check("ring", got, PAT);
         if (k != 2) check("drive", BSR_DRIVE, ~PAT);
         check("float", OUT_FLOAT, k == 2);
         check("extest", EXTEST_ON, k == 0);
      end
      // External test with the output bus cell low floats the memory outputs
      scan(1'b0, $bits(bst_ring_t), PAT, got);
      repeat (4) @(negedge CLK);
      check("ring", got, PAT);
      check("drive", BSR_DRIVE, PAT);
      check("float", OUT_FLOAT, 1'b1);
   endtask : t_ring

   // Five highs from shift, then identification read again
   task automatic t_tms_reset;
      logic s;
      host.step(1'b1, 1'b1, s);
      host.step(1'b0, 1'b1, s);
      host.step(1'b0, 1'b1, s);
      repeat (5) host.step(1'b1, 1'b1, s);
      check("tms reset", TAP_STATE, ST_RESET);
      repeat (4) @(negedge CLK);
      check("extest in reset", EXTEST_ON, 1'b0);
      check("float in reset", OUT_FLOAT, 1'b0);
      t_id_read();
      check("extest off", EXTEST_ON, 1'b0);
   endtask : t_tms_reset

   // System clock
   initial begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end

   // Hang guard
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         wrap_up();
      end
   end

   // Main sequence
   initial begin
      RST_B = 1'b0;
      PIN_RING = '0;
      repeat (20) @(negedge CLK);
      RST_B = 1'b1;
      repeat (3) @(negedge CLK);
      t_power_up();
      t_id_read();
      t_bypass();
      t_ring();
      t_tms_reset();
      wrap_up();
   end
endmodule : boundary_scan_tap_test

bind bst_tap bst_tap_props chk (.CLK(CLK), .RST_B(RST_B), .TCK(TCK), .TMS(TMS), .TDI(TDI),
   .PIN_RING(PIN_RING), .TAP_STATE(TAP_STATE), .TDO(TDO), .TDO_OE(TDO_OE),
   .EXTEST_ON(EXTEST_ON), .OUT_FLOAT(OUT_FLOAT), .BSR_DRIVE(BSR_DRIVE));
